// ---- shared/pcie_aer_pkg.sv ----
package pcie_aer_pkg;

   localparam int ADDR_W = 12;

   // register byte offsets
   localparam logic [11:0] CORR_STATUS_OFF = 12'h110;
   localparam logic [11:0] CORR_MASK_OFF = 12'h114;
   localparam logic [11:0] CAP_CTRL_OFF = 12'h118;
   localparam logic [11:0] HDR_LOG0_OFF = 12'h11C;
   localparam logic [11:0] HDR_LOG1_OFF = 12'h120;
   localparam logic [11:0] HDR_LOG2_OFF = 12'h124;

   // correctable error field positions, shared by status and mask
   localparam int RECEIVER_FAULT_BIT = 0;
   localparam int BAD_TRANSACTION_PACKET_BIT = 6;
   localparam int BAD_LINK_PACKET_BIT = 7;
   localparam int REPLAY_COUNT_WRAP_BIT = 8;
   localparam int REPLAY_TIMER_EXPIRY_BIT = 12;
   localparam int ADVISORY_NONFATAL_BIT = 13;
   localparam logic [31:0] CORR_FIELDS = 32'h0000_31C1;
   localparam logic [31:0] CORR_MASK_RESET = 32'h0000_2000;
   localparam logic [31:0] CORR_STATUS_RESET = 32'h0000_0000;

   // capability and control field positions
   localparam int CRC_CHECK_ENABLE_BIT = 8;
   localparam int CRC_CHECK_CAPABLE_BIT = 7;
   localparam int CRC_GENERATE_ENABLE_BIT = 6;
   localparam int CRC_GENERATE_CAPABLE_BIT = 5;
   localparam int FIRST_FAULT_POINTER_LSB = 0;
   localparam int FIRST_FAULT_POINTER_W = 5;
   localparam logic [31:0] CAP_CTRL_RESET = 32'h0000_00A0;
   localparam logic CRC_CHECK_ENABLE_RESET = 1'b0;
   localparam logic CRC_GENERATE_ENABLE_RESET = 1'b0;
   localparam logic [4:0] FIRST_FAULT_POINTER_RESET = 5'h00;
   localparam logic [31:0] HDR_LOG_RESET = 32'h0000_0000;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- test/pcie_aer_mask_ctrl_header_log_bench.sv ----
module pcie_aer_mask_ctrl_header_log_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset, coldReset, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, headerCapture;
   logic crcCheckEnable, crcGenerateEnable, corrErrorMessage, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [5:0] evt;
   logic [127:32] headerIn;
   logic [4:0] firstFaultIn;
   int nErrors, nChecks;

   pcie_aer_mask_ctrl_header_log u_dut
   (
      .ref_clk(ref_clk), .reset(reset), .coldReset(coldReset),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .receiverFault(evt[0]),
      .badTransactionPacket(evt[1]), .badLinkPacket(evt[2]), .replayCountWrap(evt[3]),
      .replayTimerExpiry(evt[4]), .advisoryNonfatal(evt[5]), .headerCapture(headerCapture),
      .headerIn(headerIn), .firstFaultIn(firstFaultIn), .crcCheckEnable(crcCheckEnable),
      .crcGenerateEnable(crcGenerateEnable), .corrErrorMessage(corrErrorMessage), .irq(irq)
   );

   initial
   begin
      ref_clk = 1'h0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         nErrors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic testDone();
      $display("checks %0d, mismatches %0d", nChecks, nErrors);
      if (nErrors == 0 && nChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic stuck();
      nErrors++;
      $display("unexpected bus answer: expected valid, seen none");
      testDone();
   endtask

   // flop outputs read right after the edge still show their pre-edge values
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
      input logic [1:0] er = 2'h0);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      repeat (40)
      begin
         @(posedge ref_clk);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
         if (bvalid)
         begin
            bready <= 1'h0;
            chk("write response", 32'(bresp), 32'(er));
            // one edge between calls, so a following call never re-raises bready in this step
            @(posedge ref_clk);
            return;
         end
      end
      stuck();
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      repeat (40)
      begin
         @(posedge ref_clk);
         if (arvalid && arready)
            arvalid <= 1'h0;
         if (rvalid)
         begin
            rready <= 1'h0;
            chk($sformatf("read %h", a), rdata, exp);
            chk("read response", 32'(rresp), 32'(er));
            @(posedge ref_clk);
            return;
         end
      end
      stuck();
   endtask

   task automatic doReset(input logic cold, input int n);
      reset <= 1'h1;
      coldReset <= cold;
      repeat (n) @(posedge ref_clk);
      reset <= 1'h0;
      coldReset <= 1'h0;
      @(posedge ref_clk);
   endtask

   task automatic testReset();
      rd(12'h114, 32'h0000_2000);
      rd(12'h118, 32'h0000_00A0);
      rd(12'h11C, 32'h0000_0000);
      rd(12'h120, 32'h0000_0000);
      rd(12'h124, 32'h0000_0000);
      rd(12'h110, 32'h0000_0000);
      chk("crc enables", 32'({crcCheckEnable, crcGenerateEnable}), 32'h0000_0000);
      rd(12'h200, 32'h0000_0000, pcie_aer_pkg::RESP_SLVERR);
      wr(12'h200, 32'h0000_FFFF, 4'hF, pcie_aer_pkg::RESP_SLVERR);
      $display("reset values test done");
   endtask

   task automatic testMask();
      wr(12'h114, 32'hFFFF_FFFF);
      rd(12'h114, 32'h0000_31C1);
      wr(12'h114, 32'h0000_0000);
      rd(12'h114, 32'h0000_0000);
      wr(12'h114, 32'hFFFF_FFFF, 4'h2);
      rd(12'h114, 32'h0000_3100);
      $display("mask register test done");
   endtask

   task automatic testCtrl();
      wr(12'h118, 32'hFFFF_FFFF);
      rd(12'h118, 32'h0000_01E0);
      chk("crc enables", 32'({crcCheckEnable, crcGenerateEnable}), 32'h0000_0003);
      wr(12'h118, 32'h0000_0000, 4'h1);
      rd(12'h118, 32'h0000_01A0);
      chk("crc enables", 32'({crcCheckEnable, crcGenerateEnable}), 32'h0000_0002);
      wr(12'h118, 32'h0000_0000, 4'h2);
      rd(12'h118, 32'h0000_00A0);
      chk("crc enables", 32'({crcCheckEnable, crcGenerateEnable}), 32'h0000_0000);
      $display("control register test done");
   endtask

   task automatic testEvents();
      int pos[6] = '{0, 6, 7, 8, 12, 13};
      logic [31:0] b;
      for (int k = 0; k < 12; k++)
      begin
         b = 32'h0000_0001 << pos[k / 2];
         wr(12'h114, (k % 2 == 1) ? b : 32'h0000_0000);
         evt <= 6'h01 << (k / 2);
         @(posedge ref_clk);
         evt <= 6'h00;
         @(posedge ref_clk);
         chk("message", 32'(corrErrorMessage), 32'(k % 2 == 0));
         @(posedge ref_clk);
         chk("irq", 32'(irq), 32'(k % 2 == 0));
         rd(12'h110, b);
         wr(12'h110, b);
         rd(12'h110, 32'h0000_0000);
         chk("irq", 32'(irq), 32'h0000_0000);
      end
      $display("event test done");
   endtask

   task automatic testHeader();
      headerIn <= 96'hDEAD_BEEF_0123_4567_89AB_CDEF;
      firstFaultIn <= 5'h13;
      headerCapture <= 1'h1;
      @(posedge ref_clk);
      headerCapture <= 1'h0;
      // inputs move on at once: the logs must hold what was captured
      headerIn <= 96'h0;
      firstFaultIn <= 5'h00;
      rd(12'h11C, 32'hDEAD_BEEF);
      rd(12'h120, 32'h0123_4567);
      rd(12'h124, 32'h89AB_CDEF);
      rd(12'h118, 32'h0000_00B3);
      wr(12'h120, 32'hFFFF_FFFF);
      rd(12'h120, 32'h0123_4567);
      $display("header log test done");
   endtask

   task automatic testSticky();
      wr(12'h114, 32'h0000_0141);
      wr(12'h118, 32'h0000_0140);
      evt <= 6'h01;
      @(posedge ref_clk);
      evt <= 6'h00;
      doReset(1'h0, 2);
      rd(12'h114, 32'h0000_0141);
      rd(12'h118, 32'h0000_01F3);
      rd(12'h110, 32'h0000_0001);
      rd(12'h11C, 32'hDEAD_BEEF);
      doReset(1'h1, 2);
      rd(12'h114, 32'h0000_2000);
      rd(12'h118, 32'h0000_00A0);
      rd(12'h110, 32'h0000_0000);
      rd(12'h124, 32'h0000_0000);
      chk("crc enables", 32'({crcCheckEnable, crcGenerateEnable}), 32'h0000_0000);
      $display("sticky reset test done");
   endtask

   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, headerCapture} = 6'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      evt = 6'h00;
      headerIn = 96'h0;
      firstFaultIn = 5'h00;
      nErrors = 0;
      nChecks = 0;
      doReset(1'h1, 8);
      testReset();
      testMask();
      testCtrl();
      testEvents();
      testHeader();
      testSticky();
      testDone();
   end
endmodule // pcie_aer_mask_ctrl_header_log_bench

// ---- verilog/axi_lite_regport.sv ----
module axi_lite_regport
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [pcie_aer_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [pcie_aer_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wrEn,
   output logic [pcie_aer_pkg::ADDR_W-1:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrStrb,
   input wire logic wrErr,
   output logic rdEn,
   output logic [pcie_aer_pkg::ADDR_W-1:0] rdAddr,
   input wire logic [31:0] rdValue,
   input wire logic rdErr
);

   // a low ready means that channel's item is held awaiting the other
   assign wrEn = !awready && !wready && !bvalid;
   assign rdEn = !arready && !rvalid;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         awready <= 1'b1;
         wrAddr <= '0;
      end
      else if (awvalid && awready)
      begin
         awready <= 1'b0;
         wrAddr <= awaddr;
      end
      else if (bvalid && bready)
         awready <= 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wready <= 1'b1;
         wrData <= '0;
         wrStrb <= '0;
      end
      else if (wvalid && wready)
      begin
         wready <= 1'b0;
         wrData <= wdata;
         wrStrb <= wstrb;
      end
      else if (bvalid && bready)
         wready <= 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         bvalid <= 1'b0;
         bresp <= pcie_aer_pkg::RESP_OKAY;
      end
      else if (wrEn)
      begin
         bvalid <= 1'b1;
         bresp <= wrErr ? pcie_aer_pkg::RESP_SLVERR : pcie_aer_pkg::RESP_OKAY;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         arready <= 1'b1;
         rdAddr <= '0;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rdAddr <= araddr;
      end
      else if (rvalid && rready)
         arready <= 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= pcie_aer_pkg::RESP_OKAY;
      end
      else if (rdEn)
      begin
         rvalid <= 1'b1;
         rdata <= rdValue;
         rresp <= rdErr ? pcie_aer_pkg::RESP_SLVERR : pcie_aer_pkg::RESP_OKAY;
      end
      else if (rready)
         rvalid <= 1'b0;
   end

endmodule // axi_lite_regport

// ---- verilog/pcie_aer_mask_ctrl_header_log.sv ----
// Function
// - advisory non-fatal mask bit13, sticky, resets 1
// - replay timer mask bit12, sticky, resets 0
// - CRC check enable bit8, sticky, resets 0
// - CRC check capable bit7 always reads 1
// - CRC generate enable bit6, sticky, resets 0
// - CRC generate capable bit5 always reads 1
// - header log dwords at 0x11C and 0x120
// - header log third dword at 0x124
// - sticky status per mask bit, write-1-clear
//
// Implementation choice: register access over AXI4-Lite.
module pcie_aer_mask_ctrl_header_log
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic coldReset,
   input wire logic [pcie_aer_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [pcie_aer_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic receiverFault,
   input wire logic badTransactionPacket,
   input wire logic badLinkPacket,
   input wire logic replayCountWrap,
   input wire logic replayTimerExpiry,
   input wire logic advisoryNonfatal,
   input wire logic headerCapture,
   input wire logic [127:32] headerIn,
   input wire logic [4:0] firstFaultIn,
   output logic crcCheckEnable,
   output logic crcGenerateEnable,
   output logic corrErrorMessage,
   output logic irq
);

   logic wrEn;
   logic [pcie_aer_pkg::ADDR_W-1:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic wrErr;
   logic rdEn;
   logic [pcie_aer_pkg::ADDR_W-1:0] rdAddr;
   logic [31:0] rdValue;
   logic rdErr;
   logic [11:0] wrWord;
   logic [11:0] rdWord;
   logic [31:0] strbBits;
   logic [31:0] corrEvents;
   logic [31:0] correctableMask;
   logic [31:0] correctableStatus;
   logic [31:0] clearBits;
   logic [4:0] firstFaultPointer;
   logic [31:0] headerLog0;
   logic [31:0] headerLog1;
   logic [31:0] headerLog2;

   axi_lite_regport bus
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .wrErr(wrErr),
      .rdEn(rdEn),
      .rdAddr(rdAddr),
      .rdValue(rdValue),
      .rdErr(rdErr)
   );

   // sub-word addresses land on the enclosing register
   assign wrWord = {wrAddr[11:2], 2'b00};
   assign rdWord = {rdAddr[11:2], 2'b00};
   assign strbBits = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};

   always_comb
   begin
      corrEvents = '0;
      corrEvents[pcie_aer_pkg::RECEIVER_FAULT_BIT] = receiverFault;
      corrEvents[pcie_aer_pkg::BAD_TRANSACTION_PACKET_BIT] = badTransactionPacket;
      corrEvents[pcie_aer_pkg::BAD_LINK_PACKET_BIT] = badLinkPacket;
      corrEvents[pcie_aer_pkg::REPLAY_COUNT_WRAP_BIT] = replayCountWrap;
      corrEvents[pcie_aer_pkg::REPLAY_TIMER_EXPIRY_BIT] = replayTimerExpiry;
      corrEvents[pcie_aer_pkg::ADVISORY_NONFATAL_BIT] = advisoryNonfatal;
   end

   always_comb
   begin
      unique case (wrWord)
         pcie_aer_pkg::CORR_STATUS_OFF,
         pcie_aer_pkg::CORR_MASK_OFF,
         pcie_aer_pkg::CAP_CTRL_OFF,
         pcie_aer_pkg::HDR_LOG0_OFF,
         pcie_aer_pkg::HDR_LOG1_OFF,
         pcie_aer_pkg::HDR_LOG2_OFF: wrErr = 1'b0;
         default: wrErr = 1'b1;
      endcase
   end

   // sticky state answers only to coldReset, so an ordinary reset keeps it
   always_ff @(posedge ref_clk)
   begin
      if (coldReset)
         correctableMask <= pcie_aer_pkg::CORR_MASK_RESET;
      else if (wrEn && wrWord == pcie_aer_pkg::CORR_MASK_OFF)
         correctableMask <= (correctableMask & ~(strbBits & pcie_aer_pkg::CORR_FIELDS))
            | (wrData & strbBits & pcie_aer_pkg::CORR_FIELDS);
   end

   assign clearBits = (wrEn && wrWord == pcie_aer_pkg::CORR_STATUS_OFF)
      ? (wrData & strbBits & pcie_aer_pkg::CORR_FIELDS) : '0;

   // a new event beats a simultaneous write-1 clear
   always_ff @(posedge ref_clk)
   begin
      if (coldReset)
         correctableStatus <= pcie_aer_pkg::CORR_STATUS_RESET;
      else
         correctableStatus <= (correctableStatus & ~clearBits) | corrEvents;
   end

   always_ff @(posedge ref_clk)
   begin
      if (coldReset)
      begin
         crcCheckEnable <= pcie_aer_pkg::CRC_CHECK_ENABLE_RESET;
         crcGenerateEnable <= pcie_aer_pkg::CRC_GENERATE_ENABLE_RESET;
      end
      else if (wrEn && wrWord == pcie_aer_pkg::CAP_CTRL_OFF)
      begin
         if (wrStrb[pcie_aer_pkg::CRC_CHECK_ENABLE_BIT / 8])
            crcCheckEnable <= wrData[pcie_aer_pkg::CRC_CHECK_ENABLE_BIT];
         if (wrStrb[pcie_aer_pkg::CRC_GENERATE_ENABLE_BIT / 8])
            crcGenerateEnable <= wrData[pcie_aer_pkg::CRC_GENERATE_ENABLE_BIT];
      end
   end

   // pointer and header are loaded by the error logger, never by software
   always_ff @(posedge ref_clk)
   begin
      if (coldReset)
      begin
         firstFaultPointer <= pcie_aer_pkg::FIRST_FAULT_POINTER_RESET;
         headerLog0 <= pcie_aer_pkg::HDR_LOG_RESET;
         headerLog1 <= pcie_aer_pkg::HDR_LOG_RESET;
         headerLog2 <= pcie_aer_pkg::HDR_LOG_RESET;
      end
      else if (headerCapture)
      begin
         firstFaultPointer <= firstFaultIn;
         headerLog0 <= headerIn[127:96];
         headerLog1 <= headerIn[95:64];
         headerLog2 <= headerIn[63:32];
      end
   end

   // message to the root only for unmasked classes
   always_ff @(posedge ref_clk)
   begin
      if (reset || coldReset)
         corrErrorMessage <= 1'b0;
      else
         corrErrorMessage <= |(corrEvents & ~correctableMask);
   end

   // interrupt lags status by one cycle
   always_ff @(posedge ref_clk)
   begin
      if (reset || coldReset)
         irq <= 1'b0;
      else
         irq <= |(correctableStatus & ~correctableMask);
   end

   always_comb
   begin
      rdValue = '0;
      rdErr = 1'b0;
      unique case (rdWord)
         pcie_aer_pkg::CORR_STATUS_OFF: rdValue = correctableStatus;
         pcie_aer_pkg::CORR_MASK_OFF: rdValue = correctableMask;
         pcie_aer_pkg::CAP_CTRL_OFF:
         begin
            rdValue[pcie_aer_pkg::CRC_CHECK_ENABLE_BIT] = crcCheckEnable;
            rdValue[pcie_aer_pkg::CRC_CHECK_CAPABLE_BIT] = 1'b1;
            rdValue[pcie_aer_pkg::CRC_GENERATE_ENABLE_BIT] = crcGenerateEnable;
            rdValue[pcie_aer_pkg::CRC_GENERATE_CAPABLE_BIT] = 1'b1;
            rdValue[4:0] = firstFaultPointer;
         end
         pcie_aer_pkg::HDR_LOG0_OFF: rdValue = headerLog0;
         pcie_aer_pkg::HDR_LOG1_OFF: rdValue = headerLog1;
         pcie_aer_pkg::HDR_LOG2_OFF: rdValue = headerLog2;
         default: rdErr = 1'b1;
      endcase
   end

   mask_anf_reset_a:
      assert property (@(posedge ref_clk) $fell(coldReset)
         |-> correctableMask[pcie_aer_pkg::ADVISORY_NONFATAL_BIT])
      else $error("advisory mask not set after cold reset");

   mask_replay_reset_a:
      assert property (@(posedge ref_clk) $fell(coldReset)
         |-> !correctableMask[pcie_aer_pkg::REPLAY_TIMER_EXPIRY_BIT] && !crcCheckEnable)
      else $error("replay mask or check enable not clear after cold reset");

   check_enable_write_a:
      assert property (@(posedge ref_clk) disable iff (coldReset || reset)
         wrEn && wrWord == pcie_aer_pkg::CAP_CTRL_OFF && wrStrb[1]
         |=> crcCheckEnable == $past(wrData[8]))
      else $error("check enable did not follow write");

   check_capable_read_a:
      assert property (@(posedge ref_clk) disable iff (coldReset || reset)
         rdEn && rdWord == pcie_aer_pkg::CAP_CTRL_OFF |=> rvalid && rdata[7])
      else $error("check capable flag not read as one");

   generate_enable_write_a:
      assert property (@(posedge ref_clk) disable iff (coldReset || reset)
         wrEn && wrWord == pcie_aer_pkg::CAP_CTRL_OFF && wrStrb[0]
         |=> crcGenerateEnable == $past(wrData[6]))
      else $error("generate enable did not follow write");

   generate_capable_read_a:
      assert property (@(posedge ref_clk) disable iff (coldReset || reset)
         rdEn && rdWord == pcie_aer_pkg::CAP_CTRL_OFF
         |=> rdata[5] && rdata[4:0] == $past(firstFaultPointer))
      else $error("generate capable flag or pointer read wrong");

   pointer_hold_a:
      assert property (@(posedge ref_clk) disable iff (coldReset)
         !headerCapture |=> $stable(firstFaultPointer))
      else $error("first fault pointer changed without capture");

   header_upper_a:
      assert property (@(posedge ref_clk) disable iff (coldReset)
         headerCapture |=> headerLog0 == $past(headerIn[127:96])
            && headerLog1 == $past(headerIn[95:64]))
      else $error("upper header dwords not captured");

   header_lower_a:
      assert property (@(posedge ref_clk) disable iff (coldReset)
         headerCapture ##1 !headerCapture |=> headerLog2 == $past(headerIn[63:32], 2))
      else $error("third header dword not captured or not held");

   mask_reserved_a:
      assert property (@(posedge ref_clk) disable iff (coldReset || reset)
         rdEn && rdWord == pcie_aer_pkg::CORR_MASK_OFF
         |=> (rdata & ~pcie_aer_pkg::CORR_FIELDS) == 32'h0000_0000)
      else $error("reserved mask bits read nonzero");

   masked_silent_a:
      assert property (@(posedge ref_clk) disable iff (coldReset || reset)
         corrEvents != 32'h0000_0000 && (corrEvents & ~correctableMask) == 32'h0000_0000
         |=> !corrErrorMessage && (correctableStatus & $past(corrEvents)) != 32'h0000_0000)
      else $error("masked error signalled or not recorded");

   status_set_wins_a:
      assert property (@(posedge ref_clk) disable iff (coldReset)
         corrEvents != 32'h0000_0000
         |=> (correctableStatus & $past(corrEvents)) == $past(corrEvents))
      else $error("error event lost against clear");

endmodule // pcie_aer_mask_ctrl_header_log
